// ---- aux_irq_error_map.vh ----
// Register map, field positions and reset values of the aux interrupt and error block
`ifndef AUX_IRQ_ERROR_MAP_VH
`define AUX_IRQ_ERROR_MAP_VH

`define OFS_AUX_ENABLES     8'h03
`define OFS_AUX_REQUESTS    8'h05
`define OFS_ERRORS          8'h06
`define OFS_CMD_CONTROL     8'h08

`define AUX_SET_BIT         7
`define AUX_FLAG_MSB        4
`define ERR_WRITE           7
`define ERR_OVERHEAT        6
`define ERR_FIELD_TIMING    5
`define ERR_OVERFLOW        4
`define ERR_COLLISION       3
`define ERR_CHECKSUM        2
`define ERR_PARITY          1
`define ERR_FRAMING         0
`define FLAG_EDGE           4
`define FLAG_MODE           3
`define FLAG_CRC            2
`define FLAG_ON             1
`define FLAG_OFF            0

`define CTL_DETECT_RUN      0
`define CTL_PUSH_PULL       7
`define FRAMING_ACTIVE      2'h1
`define RATE_106            2'h0
`define ZERO_BYTE           8'h00
`define ZERO_FLAGS          5'h00

`endif

// ---- aux_irq_error_status.v ----
// Auxiliary interrupt flags, last command error flags and their Wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "aux_irq_error_map.vh"

module aux_irq_error_status
(
    input  wire        clk,
    input  wire        rst_b,
    input  wire        clk_en,
    // Classic Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output wire        wb_ack_o,
    output wire        wb_err_o,
    // Event sources
    input  wire        secure_interface_input,
    input  wire        mode_found,
    input  wire        auto_anticollision_command,
    input  wire        card_authentication_command,
    input  wire        rf_reset,
    input  wire        checksum_command_active,
    input  wire        checksum_data_done,
    input  wire        field_present,
    input  wire        command_start,
    input  wire        host_fifo_write,
    input  wire        tx_rx_gap,
    input  wire        overheat_detect,
    input  wire        active_mode,
    input  wire        counterpart_field_late,
    input  wire [1:0]  receive_framing_select,
    input  wire [1:0]  transmit_framing_select,
    input  wire        fifo_full,
    input  wire        internal_fifo_write,
    input  wire        receiver_start,
    input  wire [1:0]  rate_select,
    input  wire        collision_seen,
    input  wire        receive_checksum_enable,
    input  wire        checksum_fail,
    input  wire        parity_fail,
    input  wire        type_a_or_p2p,
    input  wire        bad_start_of_frame,
    input  wire        sync_detect_enable,
    input  wire        sync_based_comm,
    input  wire        byte_length_violation,
    input  wire        initiator_bit,
    input  wire        auth_byte_count_bad,
    input  wire        pulses_too_close,
    // Outputs
    output wire        irq_out,
    output wire        irq_oe,
    output reg         antenna_off,
    output wire        mode_detector_running,
    output wire        summary_error_flag
);

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    reg        ack_reg;
    reg        err_reg;
    wire       req      = wb_cyc_i & wb_stb_i;
    wire       hit_en   = wb_adr_i == (`OFS_AUX_ENABLES << 2);
    wire       hit_rq   = wb_adr_i == (`OFS_AUX_REQUESTS << 2);
    wire       hit_err  = wb_adr_i == (`OFS_ERRORS << 2);
    wire       hit_ctl  = wb_adr_i == (`OFS_CMD_CONTROL << 2);
    wire       mapped   = hit_en | hit_rq | hit_err | hit_ctl;
    wire       lane0_wr = req & wb_we_i & wb_sel_i[0] & ~ack_reg & clk_en;

    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            ack_reg <= req & mapped & ~ack_reg & ~err_reg;
            err_reg <= req & ~mapped & ~ack_reg & ~err_reg;
        end
    end

    // ****************************************************************
    // Enables and detector control
    // ****************************************************************
    reg [7:0] enables_reg;
    reg       detect_run_reg;
    reg       sig_prev_reg;
    reg       field_prev_reg;

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            enables_reg    <= `ZERO_BYTE;
            detect_run_reg <= 1'b0;
            sig_prev_reg   <= 1'b0;
            field_prev_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            sig_prev_reg   <= secure_interface_input;
            field_prev_reg <= field_present;
            if (lane0_wr && hit_en)
                enables_reg <= wb_dat_i[7:0] & 8'h9f;
            if (auto_anticollision_command || rf_reset)
                detect_run_reg <= 1'b1;
            else if (mode_found && detect_run_reg)
                detect_run_reg <= 1'b0;
        end
    end

    assign mode_detector_running = detect_run_reg;

    // ****************************************************************
    // Auxiliary flags
    // ****************************************************************
    wire [4:0] events;
    assign events[`FLAG_EDGE] = secure_interface_input ^ sig_prev_reg;
    assign events[`FLAG_MODE] = mode_found & detect_run_reg;
    assign events[`FLAG_CRC]  = checksum_command_active & checksum_data_done;
    assign events[`FLAG_ON]   = field_present & ~field_prev_reg;
    assign events[`FLAG_OFF]  = ~field_present & field_prev_reg;

    reg  [4:0] flags_reg;
    reg  [4:0] flags_next;
    wire [4:0] wr_mask = (lane0_wr && hit_rq) ? wb_dat_i[`AUX_FLAG_MSB:0] : `ZERO_FLAGS;
    wire       set_sel = wb_dat_i[`AUX_SET_BIT];

    always @*
    begin
        flags_next = flags_reg;
        if (set_sel)
            flags_next = flags_next | wr_mask;
        else
            flags_next = flags_next & ~wr_mask;
        flags_next = flags_next | events;
    end

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            flags_reg <= `ZERO_FLAGS;
        else if (clk_en)
            flags_reg <= flags_next;
    end

    // ****************************************************************
    // Error flags
    // ****************************************************************
    wire       fast_rate  = rate_select != `RATE_106;
    wire       framing_ok = (receive_framing_select == `FRAMING_ACTIVE) |
                            (transmit_framing_select == `FRAMING_ACTIVE);
    wire [7:0] err_set;
    assign err_set[`ERR_WRITE]        = host_fifo_write & (auto_anticollision_command |
                                        card_authentication_command | tx_rx_gap);
    assign err_set[`ERR_OVERHEAT]     = overheat_detect;
    assign err_set[`ERR_FIELD_TIMING] = active_mode & counterpart_field_late & framing_ok;
    assign err_set[`ERR_OVERFLOW]     = fifo_full & (host_fifo_write | internal_fifo_write);
    assign err_set[`ERR_COLLISION]    = collision_seen;
    assign err_set[`ERR_CHECKSUM]     = receive_checksum_enable & checksum_fail;
    assign err_set[`ERR_PARITY]       = parity_fail & type_a_or_p2p & ~fast_rate;
    assign err_set[`ERR_FRAMING]      = (bad_start_of_frame & ~fast_rate)
        | (sync_detect_enable & byte_length_violation &
           (sync_based_comm | (active_mode & fast_rate)))
        | (auto_anticollision_command & initiator_bit)
        | (card_authentication_command & auth_byte_count_bad)
        | pulses_too_close;

    reg  [7:0] errors_reg;
    reg  [7:0] errors_next;
    wire [7:0] rx_clear = {4'h0, 4'hf} & {8{receiver_start}};

    always @*
    begin
        errors_next = errors_reg;
        if (command_start)
            errors_next = errors_next & (8'h01 << `ERR_OVERHEAT);
        errors_next = errors_next & ~rx_clear;
        errors_next = errors_next | err_set;
        if (fast_rate)
            errors_next[`ERR_COLLISION] = 1'b1;
    end

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            errors_reg  <= `ZERO_BYTE;
            antenna_off <= 1'b0;
        end
        else if (clk_en)
        begin
            errors_reg <= errors_next;
            if (overheat_detect)
                antenna_off <= 1'b1;
            else if (command_start)
                antenna_off <= 1'b0;
        end
    end

    assign summary_error_flag = |errors_reg;

    // ****************************************************************
    // Interrupt pin and read data
    // ****************************************************************
    wire irq_level = |(flags_reg & enables_reg[`AUX_FLAG_MSB:0]);
    assign irq_out = irq_level;
    assign irq_oe  = enables_reg[`CTL_PUSH_PULL] | irq_level;

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            wb_dat_o <= 32'h00000000;
        else if (clk_en && req && !wb_we_i)
        begin
            if (hit_en)
                wb_dat_o <= {24'h000000, enables_reg};
            else if (hit_rq)
                wb_dat_o <= {24'h000000, 3'h0, flags_reg};
            else if (hit_err)
                wb_dat_o <= {24'h000000, errors_reg};
            else if (hit_ctl)
                wb_dat_o <= {31'h00000000, detect_run_reg};
            else
                wb_dat_o <= 32'h00000000;
        end
    end

endmodule // aux_irq_error_status

`default_nettype wire

// ---- aux_irq_error_chk.sv ----
// Port-level checks for the aux interrupt and error block
`timescale 1ns/1ps
`default_nettype none
module aux_irq_error_chk
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        clk_en,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        mode_found,
    input wire logic        auto_anticollision_command,
    input wire logic        rf_reset,
    input wire logic        overheat_detect,
    input wire logic [1:0]  rate_select,
    input wire logic        irq_out,
    input wire logic        irq_oe,
    input wire logic        antenna_off,
    input wire logic        mode_detector_running,
    input wire logic        summary_error_flag
);
    // ****************************************
    // Bus and flag properties
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence req_s;
        wb_cyc_i && wb_stb_i && clk_en && !wb_ack_o && !wb_err_o;
    endsequence
    sequence rd_aux_s;
        req_s ##0 (!wb_we_i && wb_adr_i == 8'h14);
    endsequence
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    req_answer_a: assert property (req_s |=> wb_ack_o || wb_err_o)
        else $error("request not answered");
    unmapped_err_a: assert property
        (req_s ##0 !(wb_adr_i inside {8'h0c, 8'h14, 8'h18, 8'h20}) |=> wb_err_o && !wb_ack_o)
        else $error("unmapped address not refused");
    aux_reserved_a: assert property (rd_aux_s |=> wb_dat_o[31:5] == 27'h0)
        else $error("aux reserved bits not zero");
    overheat_off_a: assert property
        (overheat_detect && clk_en |=> antenna_off && summary_error_flag)
        else $error("overheat not flagged");
    irq_drive_a: assert property (irq_out |-> irq_oe)
        else $error("irq high but not driven");
    detector_start_a: assert property
        (rf_reset && !mode_found && clk_en |=> mode_detector_running)
        else $error("detector not restarted");
    detector_stop_a: assert property
        (mode_found && !rf_reset && !auto_anticollision_command && clk_en
         |=> !mode_detector_running)
        else $error("detector not stopped");
    fast_collision_a: assert property
        ((rate_select != 2'h0 && clk_en) [*2] |-> summary_error_flag)
        else $error("collision not forced at fast rate");
    freeze_hold_a: assert property
        (!clk_en |=> $stable(antenna_off) && $stable(mode_detector_running))
        else $error("state moved while frozen");
endmodule // aux_irq_error_chk
bind aux_irq_error_status aux_irq_error_chk chk
(
    .clk, .rst_b, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
    .wb_err_o, .mode_found, .auto_anticollision_command, .rf_reset, .overheat_detect,
    .rate_select, .irq_out, .irq_oe, .antenna_off, .mode_detector_running, .summary_error_flag
);
`default_nettype wire

// ---- wb_host.sv ----
// Classic Wishbone host model for register traffic
`timescale 1ns/1ps
`default_nettype none
module wb_host
(
    input  wire logic        clk,
    input  wire logic        ack,
    input  wire logic        err,
    input  wire logic [31:0] rdat,
    output logic             cyc,
    output logic             we,
    output logic [7:0]       adr,
    output logic [31:0]      wdat,
    output logic             hung
);
    // ****************************************
    // Single cycle, bounded wait for the answer
    // ****************************************
    initial {cyc, we, adr, wdat, hung} = '0;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic e);
        int n;
        @(posedge clk);
        {cyc, we, adr, wdat} <= {1'b1, w, a, 24'h0, d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (!(ack || err) && n < 50);
        hung = !(ack || err);
        // Released data lines show the inverse so stale values never match
        {cyc, wdat} <= {1'b0, ~wdat};
        q = rdat[7:0];
        e = err;
    endtask
endmodule // wb_host
`default_nettype wire

// ---- nfc_aux_irq_error_status_test.sv ----
// Self-checking bench for the aux interrupt and error block
`timescale 1ns/1ps
`default_nettype none
module nfc_aux_irq_error_status_test;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        clk_en = 1'b1;
    logic [35:0] ev = '0;
    logic [7:0]  adr, q;
    logic [31:0] wdat, rdat;
    logic        cyc, we, hung, ack, err, e, irq_out, irq_oe, ant_off, summary, det_run;
    int          err_total = 0;
    int          checked = 0;
    logic [51:0] rows [25] = '{
        {36'h4000004, 16'h0001}, {36'h10000000, 16'h0001},
        {36'h1, 16'h1000}, {36'h60, 16'h0400}, {36'h20, 16'h0000}, {36'h80, 16'h0300},
        {36'h10, 16'h0000}, {36'h2, 16'h0800}, {36'h2, 16'h0000}, {36'h200, 16'h0000},
        {36'h204, 16'h0080}, {36'h208, 16'h0080}, {36'h600, 16'h0080},
        {36'h80003000, 16'h0020}, {36'h200003000, 16'h0020}, {36'h3000, 16'h0000},
        {36'hc000, 16'h0010}, {36'h20000, 16'h0008}, {36'hc0000, 16'h0004},
        {36'h80000, 16'h0000}, {36'h300000, 16'h0002}, {36'h100000, 16'h0000},
        {36'h400000, 16'h0001}, {36'h3800000, 16'h0001}, {36'h8000008, 16'h0001}};
    always #2.5 clk = ~clk;
    wb_host host
    (
        .clk(clk), .ack(ack), .err(err), .rdat(rdat), .cyc(cyc), .we(we), .adr(adr),
        .wdat(wdat), .hung(hung)
    );
    aux_irq_error_status dut
    (
        .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .secure_interface_input(ev[0]), .mode_found(ev[1]),
        .auto_anticollision_command(ev[2]), .card_authentication_command(ev[3]),
        .rf_reset(ev[4]), .checksum_command_active(ev[5]), .checksum_data_done(ev[6]),
        .field_present(ev[7]), .command_start(ev[8]), .host_fifo_write(ev[9]),
        .tx_rx_gap(ev[10]), .overheat_detect(ev[11]), .active_mode(ev[12]),
        .counterpart_field_late(ev[13]), .fifo_full(ev[14]), .internal_fifo_write(ev[15]),
        .receiver_start(ev[16]), .collision_seen(ev[17]), .receive_checksum_enable(ev[18]),
        .checksum_fail(ev[19]), .parity_fail(ev[20]), .type_a_or_p2p(ev[21]),
        .bad_start_of_frame(ev[22]), .sync_detect_enable(ev[23]), .sync_based_comm(ev[24]),
        .byte_length_violation(ev[25]), .initiator_bit(ev[26]), .auth_byte_count_bad(ev[27]),
        .pulses_too_close(ev[28]), .rate_select(ev[30:29]), .receive_framing_select(ev[32:31]),
        .transmit_framing_select(ev[34:33]), .irq_out(irq_out), .irq_oe(irq_oe),
        .antenna_off(ant_off), .mode_detector_running(det_run), .summary_error_flag(summary)
    );
    // ****************************************
    // Helpers and sequence
    // ****************************************
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic summarize;
        if (err_total == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        host.xfer(w, a, d, q, e);
        if (hung)
        begin
            err_total++;
            summarize();
        end
    endtask
    task automatic pulse(input logic [35:0] m, input int n);
        @(posedge clk);
        ev <= m;
        repeat (n) @(posedge clk);
        ev <= '0;
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        clk_en <= 1'b0;
        repeat (2) @(posedge clk);
        clk_en <= 1'b1;
        bus(0, 8'h18, 8'h0);
        chk("err_reset", q, 8'h00);
        bus(0, 8'h10, 8'h0);
        chk("unmapped", {7'h0, e}, 8'h01);
        bus(1, 8'h0c, 8'h1f);
        foreach (rows[i])
        begin
            pulse(rows[i][51:16], 1);
            bus(0, 8'h14, 8'h0);
            chk("aux", q, rows[i][15:8]);
            chk("irq", {7'h0, irq_out}, {7'h0, |rows[i][15:8]});
            bus(0, 8'h18, 8'h0);
            chk("err", q, rows[i][7:0]);
            chk("sum", {7'h0, summary}, {7'h0, |rows[i][7:0]});
            bus(1, 8'h14, 8'h1f);
            pulse(36'h100, 1);
        end
        chk("det_run", {7'h0, det_run}, 8'h01);
        bus(0, 8'h20, 8'h0);
        chk("ctl", q, 8'h01);
        bus(1, 8'h14, 8'hff);
        bus(0, 8'h14, 8'h0);
        chk("aux_set", q, 8'h1f);
        bus(1, 8'h14, 8'h05);
        bus(0, 8'h14, 8'h0);
        chk("aux_keep", q, 8'h1a);
        bus(1, 8'h0c, 8'h80);
        chk("irq_mask", {6'h0, irq_out, irq_oe}, 8'h01);
        pulse(36'h20000000, 2);
        pulse(36'h800, 1);
        @(negedge clk);
        chk("ant_off", {7'h0, ant_off}, 8'h01);
        pulse(36'h10100, 1);
        bus(1, 8'h18, 8'hff);
        bus(0, 8'h18, 8'h0);
        chk("err_keep", q, 8'h40);
        summarize();
    end
endmodule // nfc_aux_irq_error_status_test
`default_nettype wire
